// ==== bmc_pkg.sv ====
package bmc_pkg;
	// ==========================================
	// register addresses
	localparam logic [4:0] ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h01;

	// ==========================================
	// control field positions
	localparam int CTL_DATAPATH_RESET_BIT = 15;
	localparam int CTL_LOOPBACK = 14;
	localparam int CTL_AUTONEG_ENABLE_BIT = 12;
	localparam int CTL_AN_RESTART = 9;
	localparam int CTL_COL_TEST = 7;

	// ==========================================
	// status field positions and constant bits
	localparam int STS_AN_DONE = 5;
	localparam int STS_REMOTE_FAULT_LATCHED = 4;
	localparam int STS_LINK = 2;
	localparam logic [15:0] STS_FIXED = 16'h7949;

	// ==========================================
	// management frame
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] HDR_BITS = 5'h0c;
	localparam logic [4:0] TA_BITS = 5'h02;
	localparam logic [4:0] DATA_BITS = 5'h10;
	localparam logic [4:0] SKIP_BITS = 5'h12;
	localparam logic [1:0] RXD_NO_AN = 2'h3;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	typedef enum logic [2:0] {
		MS_PRE,
		MS_START,
		MS_HDR,
		MS_TA_RD,
		MS_RD,
		MS_TA_WR,
		MS_WR,
		MS_SKIP
	} bmc_mdio_state_type;
endpackage

// ==== bmc_mgmt_if.sv ====
`timescale 1ns/1ps
interface bmc_mgmt_if;
	logic rd_stb;
	logic wr_stb;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic hit;

	modport engine
	(
		output rd_stb,
		output wr_stb,
		output addr,
		output wdata,
		input rdata,
		input hit
	);
	modport regs
	(
		input rd_stb,
		input wr_stb,
		input addr,
		input wdata,
		output rdata,
		output hit
	);
endinterface

// ==== bmc_mdio_slave.sv ====
`timescale 1ns/1ps
module bmc_mdio_slave #(
	parameter logic [4:0] PHY_ADDR = 5'h00
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_b_out,
	bmc_mgmt_if.engine bus
);
	logic mdc_s1_r, mdc_s2_r, mdc_s3_r, mdio_s1_r, mdio_s2_r;
	logic prev_r, hit_r, rd_pend_r, rd_stb_r, wr_stb_r;
	logic [15:0] sh_r, data_r;
	logic [4:0] cnt_r, addr_r;
	bmc_pkg::bmc_mdio_state_type st_r;

	wire rise = mdc_s2_r & ~mdc_s3_r;
	wire bit_v = mdio_s2_r;
	wire [11:0] hdr = {sh_r[10:0], bit_v};
	wire hdr_match = hdr[9:5] == PHY_ADDR;
	wire hdr_last = cnt_r == bmc_pkg::HDR_BITS - 5'h01;

	assign bus.rd_stb = rd_stb_r;
	assign bus.wr_stb = wr_stb_r;
	assign bus.addr = addr_r;
	assign bus.wdata = data_r;

	// ==========================================
	// pin synchronisers; edge detect uses second and third stage only
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mdc_s1_r <= 1'b0;
			mdc_s2_r <= 1'b0;
			mdc_s3_r <= 1'b0;
			mdio_s1_r <= 1'b1;
			mdio_s2_r <= 1'b1;
		end
		else
		begin
			mdc_s1_r <= mdc_in;
			mdc_s2_r <= mdc_s1_r;
			mdc_s3_r <= mdc_s2_r;
			mdio_s1_r <= mdio_in;
			mdio_s2_r <= mdio_s1_r;
		end
	end

	// ==========================================
	// frame engine; preamble suppression: one idle one before start is enough
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_r <= bmc_pkg::MS_PRE;
			prev_r <= 1'b0;
			hit_r <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_stb_r <= 1'b0;
			wr_stb_r <= 1'b0;
			sh_r <= 16'h0000;
			data_r <= 16'h0000;
			cnt_r <= 5'h00;
			addr_r <= 5'h00;
			mdio_out <= 1'b1;
			mdio_oe_b_out <= 1'b1;
		end
		else
		begin
			rd_stb_r <= rd_pend_r;
			rd_pend_r <= 1'b0;
			wr_stb_r <= 1'b0;
			// register answer sampled in the strobe cycle, before latches update
			if (rd_stb_r)
			begin
				data_r <= bus.rdata;
				hit_r <= bus.hit;
			end
			if (rise)
			begin
				prev_r <= bit_v;
				case (st_r)
					bmc_pkg::MS_PRE:
					begin
						if (prev_r && !bit_v)
							st_r <= bmc_pkg::MS_START;
					end
					bmc_pkg::MS_START:
					begin
						cnt_r <= 5'h00;
						st_r <= bit_v ? bmc_pkg::MS_HDR : bmc_pkg::MS_PRE;
					end
					bmc_pkg::MS_HDR:
					begin
						sh_r <= {sh_r[14:0], bit_v};
						cnt_r <= cnt_r + 5'h01;
						if (hdr_last)
						begin
							cnt_r <= 5'h00;
							addr_r <= hdr[4:0];
							st_r <= bmc_pkg::MS_SKIP;
							if (hdr_match && hdr[11:10] == bmc_pkg::OP_READ)
							begin
								rd_pend_r <= 1'b1;
								st_r <= bmc_pkg::MS_TA_RD;
							end
							else if (hdr_match && hdr[11:10] == bmc_pkg::OP_WRITE)
								st_r <= bmc_pkg::MS_TA_WR;
						end
					end
					bmc_pkg::MS_TA_RD:
					begin
						// unmapped address: leave the line released
						mdio_out <= 1'b0;
						mdio_oe_b_out <= ~hit_r;
						cnt_r <= 5'h00;
						st_r <= bmc_pkg::MS_RD;
					end
					bmc_pkg::MS_RD:
					begin
						if (cnt_r == bmc_pkg::DATA_BITS)
						begin
							mdio_oe_b_out <= 1'b1;
							mdio_out <= 1'b1;
							prev_r <= 1'b0;
							st_r <= bmc_pkg::MS_PRE;
						end
						else
						begin
							mdio_out <= data_r[15];
							data_r <= {data_r[14:0], 1'b0};
							cnt_r <= cnt_r + 5'h01;
						end
					end
					bmc_pkg::MS_TA_WR:
					begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == bmc_pkg::TA_BITS - 5'h01)
						begin
							cnt_r <= 5'h00;
							st_r <= bmc_pkg::MS_WR;
						end
					end
					bmc_pkg::MS_WR:
					begin
						data_r <= {data_r[14:0], bit_v};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == bmc_pkg::DATA_BITS - 5'h01)
						begin
							wr_stb_r <= 1'b1;
							prev_r <= 1'b0;
							st_r <= bmc_pkg::MS_PRE;
						end
					end
					bmc_pkg::MS_SKIP:
					begin
						// frame for another station: do not mistake its data for a start
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == bmc_pkg::SKIP_BITS - 5'h01)
						begin
							prev_r <= 1'b0;
							st_r <= bmc_pkg::MS_PRE;
						end
					end
					default:
						st_r <= bmc_pkg::MS_PRE;
				endcase
			end
		end
	end
endmodule

// ==== bmc_top.sv ====
`timescale 1ns/1ps
module bmc_top #(
	parameter logic [4:0] PHY_ADDR = 5'h00
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_b_out,
	input wire logic col_in,
	output logic col_out,
	output logic col_oe_b_out,
	input wire logic rx_dv_in,
	input wire logic [1:0] rxd_in,
	input wire logic tx_en_in,
	input wire logic link_up_in,
	input wire logic remote_fault_in,
	input wire logic autoneg_done_in,
	output logic datapath_reset_out,
	output logic loopback_out,
	output logic autoneg_enable_out,
	output logic autoneg_restart_out
);
	bmc_mgmt_if mgmt ();

	logic col_s1_r, col_s2_r, dv_s1_r, dv_s2_r;
	logic [1:0] rxd_s1_r, rxd_s2_r, strap_cnt_r;
	logic strap_done_r, col_test_r, link_up_latched_r, remote_fault_latched_r;

	bmc_mdio_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_mdio (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.mdc_in(mdc_in),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe_b_out(mdio_oe_b_out),
		.bus(mgmt.engine)
	);

	// ==========================================
	// decode
	wire sel_ctl = mgmt.addr == bmc_pkg::ADDR_CONTROL;
	wire sel_sts = mgmt.addr == bmc_pkg::ADDR_STATUS;
	wire wr_ctl = mgmt.wr_stb & sel_ctl;
	wire rd_sts = mgmt.rd_stb & sel_sts;
	wire strap_an = col_s2_r | (dv_s2_r & (rxd_s2_r != bmc_pkg::RXD_NO_AN));
	wire autoneg_enable_bit_nxt = !strap_done_r ? strap_an : (wr_ctl ? mgmt.wdata[bmc_pkg::CTL_AUTONEG_ENABLE_BIT] : autoneg_enable_out);
	wire loop_nxt = wr_ctl ? mgmt.wdata[bmc_pkg::CTL_LOOPBACK] : loopback_out;
	wire col_test_nxt = wr_ctl ? mgmt.wdata[bmc_pkg::CTL_COL_TEST] : col_test_r;
	// down wins over a read in the same cycle
	wire link_nxt = !link_up_in ? 1'b0 : (rd_sts ? 1'b1 : link_up_latched_r);
	wire remote_fault_latched_nxt = remote_fault_in ? 1'b1 : (rd_sts ? 1'b0 : remote_fault_latched_r);

	wire [15:0] ctl_word = 16'h0000
		| (16'(loopback_out) << bmc_pkg::CTL_LOOPBACK)
		| (16'(autoneg_enable_out) << bmc_pkg::CTL_AUTONEG_ENABLE_BIT)
		| (16'(col_test_r) << bmc_pkg::CTL_COL_TEST);
	wire [15:0] sts_word = bmc_pkg::STS_FIXED
		| (16'(autoneg_done_in) << bmc_pkg::STS_AN_DONE)
		| (16'(remote_fault_latched_r) << bmc_pkg::STS_REMOTE_FAULT_LATCHED)
		| (16'(link_up_latched_r) << bmc_pkg::STS_LINK);
	assign mgmt.rdata = sel_ctl ? ctl_word : (sel_sts ? sts_word : 16'h0000);
	assign mgmt.hit = sel_ctl | sel_sts;

	// ==========================================
	// strap pins; value taken only after two sync stages settle
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			col_s1_r <= 1'b0;
			col_s2_r <= 1'b0;
			dv_s1_r <= 1'b0;
			dv_s2_r <= 1'b0;
			rxd_s1_r <= 2'h0;
			rxd_s2_r <= 2'h0;
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
		end
		else
		begin
			col_s1_r <= col_in;
			col_s2_r <= col_s1_r;
			dv_s1_r <= rx_dv_in;
			dv_s2_r <= dv_s1_r;
			rxd_s1_r <= rxd_in;
			rxd_s2_r <= rxd_s1_r;
			if (strap_cnt_r != bmc_pkg::STRAP_WAIT)
				strap_cnt_r <= strap_cnt_r + 2'h1;
			strap_done_r <= strap_cnt_r == bmc_pkg::STRAP_WAIT;
		end
	end

	// ==========================================
	// control and status state
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			datapath_reset_out <= 1'b0;
			autoneg_restart_out <= 1'b0;
			loopback_out <= 1'b0;
			autoneg_enable_out <= 1'b0;
			col_test_r <= 1'b0;
			link_up_latched_r <= 1'b0;
			remote_fault_latched_r <= 1'b0;
		end
		else
		begin
			datapath_reset_out <= wr_ctl & mgmt.wdata[bmc_pkg::CTL_DATAPATH_RESET_BIT];
			autoneg_restart_out <= wr_ctl & mgmt.wdata[bmc_pkg::CTL_AN_RESTART];
			loopback_out <= loop_nxt;
			autoneg_enable_out <= autoneg_enable_bit_nxt;
			col_test_r <= col_test_nxt;
			link_up_latched_r <= link_nxt;
			remote_fault_latched_r <= remote_fault_latched_nxt;
		end
	end

	// ==========================================
	// collision pin: released until strap sampled, then driven
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			col_out <= 1'b0;
			col_oe_b_out <= 1'b1;
		end
		else
		begin
			col_oe_b_out <= ~strap_done_r;
			col_out <= col_test_r & tx_en_in;
		end
	end
endmodule

// ==== bmc_asserts.sv ====
`timescale 1ns/1ps
module bmc_asserts
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_b_out,
	input wire logic col_in,
	input wire logic col_out,
	input wire logic col_oe_b_out,
	input wire logic rx_dv_in,
	input wire logic [1:0] rxd_in,
	input wire logic tx_en_in,
	input wire logic datapath_reset_out,
	input wire logic loopback_out,
	input wire logic autoneg_enable_out,
	input wire logic autoneg_restart_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic strap_r;
	logic strap_nxt;
	// strap taken while the collision pin is still released
	assign cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
	assign strap_nxt = (cnt_r == 3'h1) ? (col_in | (rx_dv_in & (rxd_in != 2'h3))) : strap_r;
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_r <= 3'h0;
			strap_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			strap_r <= strap_nxt;
		end
	end
	// ==========
	// properties
	property p_strap; cnt_r == 3'h5 |-> autoneg_enable_out == strap_r && !col_oe_b_out; endproperty
	a_strap: assert property (p_strap) else $error("strap value not loaded");
	property p_col_cause; col_out |-> $past(tx_en_in); endproperty
	a_col_cause: assert property (p_col_cause) else $error("collision without transmit");
	property p_col_fall; $fell(tx_en_in) |=> !col_out; endproperty
	a_col_fall: assert property (p_col_fall) else $error("collision held too long");
	property p_ta; $fell(mdio_oe_b_out) |-> !mdio_out; endproperty
	a_ta: assert property (p_ta) else $error("turnaround not zero");
	property p_dp; datapath_reset_out |-> mdio_oe_b_out ##1 !datapath_reset_out; endproperty
	a_dp: assert property (p_dp) else $error("datapath reset not one pulse");
	property p_rs; autoneg_restart_out |-> mdio_oe_b_out ##1 !autoneg_restart_out; endproperty
	a_rs: assert property (p_rs) else $error("restart not one pulse");
	property p_lb; $changed(loopback_out) |-> mdio_oe_b_out; endproperty
	a_lb: assert property (p_lb) else $error("loopback changed during read");
	property p_an; $changed(autoneg_enable_out) && cnt_r == 3'h7 |-> mdio_oe_b_out; endproperty
	a_an: assert property (p_an) else $error("autoneg enable changed during read");
endmodule
bind bmc_top bmc_asserts bmc_asserts_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .mdio_out(mdio_out),
	.mdio_oe_b_out(mdio_oe_b_out), .col_in(col_in), .col_out(col_out), .col_oe_b_out(col_oe_b_out),
	.rx_dv_in(rx_dv_in), .rxd_in(rxd_in), .tx_en_in(tx_en_in), .datapath_reset_out(datapath_reset_out),
	.loopback_out(loopback_out), .autoneg_enable_out(autoneg_enable_out), .autoneg_restart_out(autoneg_restart_out));

// ==== bmc_station.sv ====
`timescale 1ns/1ps
module bmc_station
(
	input wire logic clk_in,
	input wire logic line_in,
	output logic mdc_out,
	output logic mdio_out,
	output logic drive_out
);
	initial
	begin
		mdc_out = 1'b0;
		mdio_out = 1'b1;
		drive_out = 1'b0;
	end
	// ==========
	// frame
	// mdc idles low; read bits sampled at the end of the low phase
	task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [33:0] v;
		// two idle ones, then start 01; a leading 0111 would never show the start pair
		v = {4'hd, op, 5'h00, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 0; i < 34; i++)
		begin
			drive_out = (i < 16) || (op == bmc_pkg::OP_WRITE);
			mdio_out = v[33 - i];
			repeat (4) @(negedge clk_in);
			if (i > 17)
				rd = {rd[14:0], line_in};
			mdc_out = 1'b1;
			repeat (5) @(negedge clk_in);
			mdc_out = 1'b0;
		end
		drive_out = 1'b0;
		mdio_out = 1'b1;
		// gap so that a following frame never re-drives these in the same step
		@(negedge clk_in);
	endtask
endmodule

// ==== tb_basic_mode_control_status.sv ====
`timescale 1ns/1ps
module tb_basic_mode_control_status;
	logic clk, rst_b, col_s, dv_s, tx_en, link, rf, an_done, mdc, st_mdio, st_drv, line;
	logic mdio_o, mdio_oe_b, col_o, col_oe_b, dp, lb, autoneg_enable_bit, an_rs;
	logic [1:0] rxd_s;
	logic [15:0] rd;
	int mismatches, total_checks, dp_n, rs_n;
	// pull-up on the management line; the collision strap is driven from col_s while released
	assign line = (mdio_oe_b ? 1'b1 : mdio_o) & (st_drv ? st_mdio : 1'b1);
	bmc_top bmc_top_i(.clk_in(clk), .rst_b_in(rst_b), .mdc_in(mdc), .mdio_in(line), .mdio_out(mdio_o),
		.mdio_oe_b_out(mdio_oe_b), .col_in(col_oe_b ? col_s : col_o), .col_out(col_o), .col_oe_b_out(col_oe_b),
		.rx_dv_in(dv_s), .rxd_in(rxd_s), .tx_en_in(tx_en), .link_up_in(link), .remote_fault_in(rf),
		.autoneg_done_in(an_done), .datapath_reset_out(dp), .loopback_out(lb), .autoneg_enable_out(autoneg_enable_bit),
		.autoneg_restart_out(an_rs));
	bmc_station bmc_station_i(.clk_in(clk), .line_in(line), .mdc_out(mdc), .mdio_out(st_mdio), .drive_out(st_drv));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		dp_n += (dp === 1'b1);
		rs_n += (an_rs === 1'b1);
	end
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd_reg(input logic [4:0] a);
		bmc_station_i.xfer(bmc_pkg::OP_READ, a, 16'h0000, rd);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] x;
		bmc_station_i.xfer(bmc_pkg::OP_WRITE, a, d, x);
		repeat (10) @(negedge clk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic do_reset(input logic c, input logic v, input logic [1:0] r, input logic e);
		@(negedge clk);
		rst_b = 1'b0;
		col_s = c;
		dv_s = v;
		rxd_s = r;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		repeat (8) @(negedge clk);
		chk("autoneg_enable", 16'(e), 16'(autoneg_enable_bit));
		rd_reg(bmc_pkg::ADDR_CONTROL);
		chk("control_reset", 16'(e) << bmc_pkg::CTL_AUTONEG_ENABLE_BIT, rd);
	endtask
	task automatic t_control;
		dp_n = 0;
		rs_n = 0;
		wr_reg(bmc_pkg::ADDR_CONTROL, 16'hffff);
		chk("dp_pulses", 16'h0001, 16'(dp_n));
		chk("restart_pulses", 16'h0001, 16'(rs_n));
		chk("loopback", 16'h0001, 16'(lb));
		chk("autoneg_enable", 16'h0001, 16'(autoneg_enable_bit));
		rd_reg(bmc_pkg::ADDR_CONTROL);
		chk("control", 16'h5080, rd);
		wr_reg(bmc_pkg::ADDR_CONTROL, 16'h0000);
		chk("loopback", 16'h0000, 16'(lb));
		rd_reg(bmc_pkg::ADDR_CONTROL);
		chk("control", 16'h0000, rd);
	endtask
	task automatic t_status;
		link = 1'b1;
		an_done = 1'b1;
		rd_reg(bmc_pkg::ADDR_STATUS);
		chk("status_first", 16'h7969, rd);
		wr_reg(bmc_pkg::ADDR_STATUS, 16'h0000);
		rd_reg(bmc_pkg::ADDR_STATUS);
		chk("status", 16'h796d, rd);
		link = 1'b0;
		rf = 1'b1;
		@(negedge clk);
		link = 1'b1;
		rf = 1'b0;
		an_done = 1'b0;
		rd_reg(bmc_pkg::ADDR_STATUS);
		chk("status_latched", 16'h7959, rd);
		rd_reg(bmc_pkg::ADDR_STATUS);
		chk("status_cleared", 16'h794d, rd);
	endtask
	task automatic t_collision(input logic tst);
		int n;
		wr_reg(bmc_pkg::ADDR_CONTROL, 16'(tst) << bmc_pkg::CTL_COL_TEST);
		tx_en = 1'b1;
		n = 0;
		while (col_o !== 1'b1 && n < 64)
		begin
			@(negedge clk);
			n++;
		end
		chk("col_raised", 16'(tst), 16'(col_o));
		tx_en = 1'b0;
		@(negedge clk);
		chk("col_dropped", 16'h0000, 16'(col_o));
	endtask
	task automatic t_unmapped;
		logic [15:0] x;
		wr_reg(5'h02, 16'h1234);
		rd_reg(5'h02);
		chk("unmapped", 16'hffff, rd);
		// op 11 is neither read nor write: its tail must be skipped, not written
		bmc_station_i.xfer(2'h3, bmc_pkg::ADDR_CONTROL, 16'hffff, x);
		rd_reg(bmc_pkg::ADDR_CONTROL);
		chk("control", 16'h0000, rd);
	endtask
	initial
	begin
		rst_b = 1'b0;
		{col_s, dv_s, rxd_s, tx_en, link, rf, an_done} = 8'h00;
		mismatches = 0;
		total_checks = 0;
		do_reset(1'b1, 1'b0, 2'h3, 1'b1);
		do_reset(1'b0, 1'b1, 2'h3, 1'b0);
		do_reset(1'b0, 1'b1, 2'h1, 1'b1);
		do_reset(1'b0, 1'b0, 2'h0, 1'b0);
		t_control();
		t_status();
		t_collision(1'b1);
		t_collision(1'b0);
		t_unmapped();
		final_report();
	end
	initial
	begin
		#200us;
		mismatches++;
		final_report();
	end
endmodule
